// *** rtl/fss_top.sv ***
// Fault status summary: detailed flags, summary byte and word, alert
// Functional notes
// - Command 78h returns six read-only critical-fault summary bits; bits 7 and 3 read 0.
// - Summary bit 6 is 1 whenever the converter is not enabled.
// - Summary bit 5 mirrors the voltage register overvoltage fault flag.
// - Summary bit 4 mirrors the current register overcurrent fault flag.
// - Summary bits ignore writes; they clear only when their source flags or live inputs clear.
// - In loop slave configuration the overvoltage summary bit reads 0.
// - Summary bit 2 sets on any temperature fault or warning.
// - Summary bit 1 sets on any communication, memory or logic fault.
// - Summary bit 0 sets on any remaining listed fault or warning.
// - After reset summary bit 0 reads 1 since low-supply starts set.
// - Command 79h returns summary byte low plus warning/power-good high byte.
// - High bit 7 ORs all output-voltage faults and warnings.
// - High bit 6 ORs overcurrent fault and overcurrent warning.
// - High bit 5 sets while any input status flag is set.
// - High bit 4 sets on bandgap overtemperature or internal rail fault.
// - High bit 3 is live, unlatched power-not-good.
// - Power-not-good alert mask resets to 1.
// - Unmasked power-not-good alert waits for first power good.
// - Host write clears a source flag; its stored bit is its alert mask.
// - Low-supply sets at power-up, clears at first supply-on, no alert then.
`timescale 1ns/1ps
module fss_top
  import fss_pkg::*;
(
  input wire logic clk_in, // Clock, 200 MHz
  input wire logic rstn_in, // Async reset, active low
  input wire logic [7:0] cmd_in, // Command code
  input wire logic rd_req_in, // Read request pulse
  input wire logic wr_req_in, // Write request pulse
  input wire logic [15:0] wr_data_in, // Write data, ones clear flags
  input wire fss_src_t event_in, // Detailed fault conditions
  input wire fss_src_t mask_in, // Stored alert masks per flag
  input wire logic vin_low_in, // Supply below on threshold
  input wire logic vin_low_mask_in, // Alert mask for low-supply
  input wire logic [7:0] comm_status_in, // Comm status byte, live
  input wire logic conv_enabled_in, // Converter enabled
  input wire logic power_good_in, // Live power good
  input wire logic loop_slave_in, // Stacked loop slave
  input wire logic png_mask_wr_in, // Load power-not-good mask
  input wire logic png_mask_data_in, // New power-not-good mask
  output logic [15:0] rd_data_out, // Read data
  output logic rd_valid_out, // Read data valid pulse
  output logic [7:0] sum_byte_out, // Summary byte
  output logic [15:0] sum_word_out, // Summary word
  output logic alert_out // Alert request, active high
);
  // Detailed flags, raw and as seen through loop-slave forcing
  fss_src_t flag;
  fss_src_t clr;
  fss_src_t eff;
  logic lowsup;
  logic lowsup_clr;
  logic vin_on_q;
  logic vin_on_d;
  logic png_mask_q;
  logic png_mask_d;
  logic png_alert;

  // Write strobes per detailed register
  logic wr_volt;
  logic wr_curr;
  logic wr_in;
  logic wr_temp;
  logic wr_vend;

  // Register images, summaries and read data
  logic [7:0] volt_reg;
  logic [7:0] curr_reg;
  logic [7:0] input_reg;
  logic [7:0] temp_reg;
  logic [7:0] vend_reg;
  logic [7:0] sbyte;
  logic [7:0] shigh;
  logic [15:0] rdata;
  logic alert_d;

  // Helper terms and output next values
  logic first_on;
  logic lowsup_set;
  logic other_any;
  logic flag_alert;
  logic lowsup_alert;
  logic [15:0] rd_data_d;
  logic rd_valid_d;
  logic [7:0] sum_byte_d;
  logic [15:0] sum_word_d;

  // Write-one-to-clear decode; summary and comm codes have nothing to clear
  always_comb begin
    wr_volt = 1'b0;
    wr_curr = 1'b0;
    wr_in = 1'b0;
    wr_temp = 1'b0;
    wr_vend = 1'b0;
    if (wr_req_in) begin
      unique case (cmd_in)
        FSS_CMD_VOLT: wr_volt = 1'b1;
        FSS_CMD_CURR: wr_curr = 1'b1;
        FSS_CMD_INPUT: wr_in = 1'b1;
        FSS_CMD_TEMP: wr_temp = 1'b1;
        FSS_CMD_VENDOR: wr_vend = 1'b1;
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    clr = '0;
    clr.vout_overvoltage_fault = wr_volt & wr_data_in[FSS_V_OVF];
    clr.overvoltage_warning = wr_volt & wr_data_in[FSS_V_OVW];
    clr.undervoltage_warning = wr_volt & wr_data_in[FSS_V_UVW];
    clr.undervoltage_fault = wr_volt & wr_data_in[FSS_V_UVF];
    clr.setpoint_limit_warning = wr_volt & wr_data_in[FSS_V_LIM];
    clr.rise_timeout_fault = wr_volt & wr_data_in[FSS_V_RISE];
    clr.overcurrent_fault = wr_curr & wr_data_in[FSS_I_OCF];
    clr.overcurrent_warning = wr_curr & wr_data_in[FSS_I_OCW];
    clr.temp_fault = wr_temp & wr_data_in[FSS_T_OTF];
    clr.temp_warning = wr_temp & wr_data_in[FSS_T_OTW];
    clr.bandgap_overtemp_fault = wr_vend & wr_data_in[FSS_M_BG];
    clr.internal_rail_fault = wr_vend & wr_data_in[FSS_M_RAIL];
  end

  // Twelve latched source flags, set wins over a same-cycle clear
  genvar gi;
  generate
    for (gi = 0; gi < FSS_NSRC; gi++) begin : g_flag
      fss_flag #(
        .RESET_VAL(FSS_FLAG_RST)
      ) u_flag (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .set_in(event_in[gi]),
        .clr_in(clr[gi]),
        .flag_out(flag[gi])
      );
    end
  endgenerate

  // Voltage flags forced to 0 in loop slave
  always_comb begin
    eff = flag;
    if (loop_slave_in) begin
      eff.vout_overvoltage_fault = 1'b0;
      eff.overvoltage_warning = 1'b0;
      eff.undervoltage_warning = 1'b0;
      eff.undervoltage_fault = 1'b0;
      eff.setpoint_limit_warning = 1'b0;
      eff.rise_timeout_fault = 1'b0;
    end
  end

  // Low-supply: live until first supply-on, latched afterwards
  always_comb begin
    vin_on_d = vin_on_q | ~vin_low_in;
    first_on = ~vin_on_q & ~vin_low_in;
    lowsup_set = vin_low_in & vin_on_q;
    lowsup_clr = first_on | (wr_in & wr_data_in[FSS_IN_LOW]);
  end

  // Low-supply flag starts set; it only latches once supply has been on
  fss_flag #(
    .RESET_VAL(FSS_LOWSUP_RST)
  ) u_lowsup (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .set_in(lowsup_set),
    .clr_in(lowsup_clr),
    .flag_out(lowsup)
  );

  // Power-not-good mask, default masked
  always_comb begin
    png_mask_d = png_mask_q;
    if (png_mask_wr_in) begin
      png_mask_d = png_mask_data_in;
    end
  end

  // Supply-on history and power-not-good mask
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      vin_on_q <= 1'b0;
      png_mask_q <= FSS_PNG_MASK_RST;
    end else begin
      vin_on_q <= vin_on_d;
      png_mask_q <= png_mask_d;
    end
  end

  // Power-not-good alert, held off until power good first rises
  fss_png_gate u_png (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .power_good_in(power_good_in),
    .mask_in(png_mask_q),
    .alert_req_out(png_alert)
  );

  // Detailed register images
  always_comb begin
    volt_reg = '0;
    volt_reg[FSS_V_OVF] = eff.vout_overvoltage_fault;
    volt_reg[FSS_V_OVW] = eff.overvoltage_warning;
    volt_reg[FSS_V_UVW] = eff.undervoltage_warning;
    volt_reg[FSS_V_UVF] = eff.undervoltage_fault;
    volt_reg[FSS_V_LIM] = eff.setpoint_limit_warning;
    volt_reg[FSS_V_RISE] = eff.rise_timeout_fault;
    curr_reg = '0;
    curr_reg[FSS_I_OCF] = eff.overcurrent_fault;
    curr_reg[FSS_I_OCW] = eff.overcurrent_warning;
    input_reg = '0;
    input_reg[FSS_IN_LOW] = lowsup;
    temp_reg = '0;
    temp_reg[FSS_T_OTF] = eff.temp_fault;
    temp_reg[FSS_T_OTW] = eff.temp_warning;
    vend_reg = '0;
    vend_reg[FSS_M_BG] = eff.bandgap_overtemp_fault;
    vend_reg[FSS_M_RAIL] = eff.internal_rail_fault;
  end

  // Catch-all conditions for summary bit 0
  always_comb begin
    other_any = eff.undervoltage_fault |
      eff.overcurrent_warning |
      eff.overvoltage_warning |
      eff.undervoltage_warning |
      eff.rise_timeout_fault |
      lowsup |
      eff.setpoint_limit_warning |
      eff.bandgap_overtemp_fault |
      eff.internal_rail_fault;
  end

  // Summaries built purely from sources, never stored from writes
  always_comb begin
    sbyte = '0;
    sbyte[FSS_SB_OFF] = ~conv_enabled_in;
    sbyte[FSS_SB_OVF] = eff.vout_overvoltage_fault;
    sbyte[FSS_SB_OCF] = eff.overcurrent_fault;
    sbyte[FSS_SB_TEMP] = |temp_reg;
    sbyte[FSS_SB_COMM] = |comm_status_in;
    sbyte[FSS_SB_OTHER] = other_any;
  end

  // High byte: warning groups and live power-not-good
  always_comb begin
    shigh = '0;
    shigh[FSS_SW_VOLT] = |volt_reg;
    shigh[FSS_SW_CURR] = |curr_reg;
    shigh[FSS_SW_INPUT] = |input_reg;
    shigh[FSS_SW_VENDOR] = |vend_reg;
    shigh[FSS_SW_PNG] = ~power_good_in;
  end

  // Read mux; summary registers are read-only
  always_comb begin
    unique case (cmd_in)
      FSS_CMD_SUM_BYTE: rdata = {8'h00, sbyte};
      FSS_CMD_SUM_WORD: rdata = {shigh, sbyte};
      FSS_CMD_VOLT: rdata = {8'h00, volt_reg};
      FSS_CMD_CURR: rdata = {8'h00, curr_reg};
      FSS_CMD_INPUT: rdata = {8'h00, input_reg};
      FSS_CMD_TEMP: rdata = {8'h00, temp_reg};
      FSS_CMD_COMM: rdata = {8'h00, comm_status_in};
      FSS_CMD_VENDOR: rdata = {8'h00, vend_reg};
      default: rdata = 16'h0000;
    endcase
  end

  // Alert from unmasked latched flags and the power-not-good gate; summaries have no mask of their own
  always_comb begin
    flag_alert = |(flag & ~mask_in);
    lowsup_alert = lowsup & vin_on_q & ~vin_low_mask_in;
    alert_d = flag_alert | lowsup_alert | png_alert;
  end

  // Output register next values; read data holds between reads
  always_comb begin
    rd_data_d = rd_data_out;
    if (rd_req_in) begin
      rd_data_d = rdata;
    end
    rd_valid_d = rd_req_in;
    sum_byte_d = sbyte;
    sum_word_d = {shigh, sbyte};
  end

  // Every top-level output comes straight from a flip-flop
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_data_out <= 16'h0000;
      rd_valid_out <= 1'b0;
      sum_byte_out <= 8'h00;
      sum_word_out <= 16'h0000;
      alert_out <= 1'b0;
    end else begin
      rd_data_out <= rd_data_d;
      rd_valid_out <= rd_valid_d;
      sum_byte_out <= sum_byte_d;
      sum_word_out <= sum_word_d;
      alert_out <= alert_d;
    end
  end
endmodule

// *** include/fss_pkg.sv ***
// Package for the fault status summary block: command codes, bit positions, reset values
package fss_pkg;

  // Command codes
  localparam logic [7:0] FSS_CMD_SUM_BYTE = 8'h78;
  localparam logic [7:0] FSS_CMD_SUM_WORD = 8'h79;
  localparam logic [7:0] FSS_CMD_VOLT = 8'h7A;
  localparam logic [7:0] FSS_CMD_CURR = 8'h7B;
  localparam logic [7:0] FSS_CMD_INPUT = 8'h7C;
  localparam logic [7:0] FSS_CMD_TEMP = 8'h7D;
  localparam logic [7:0] FSS_CMD_COMM = 8'h7E;
  localparam logic [7:0] FSS_CMD_VENDOR = 8'h80;

  // Summary byte bit positions
  localparam int FSS_SB_OFF = 6;
  localparam int FSS_SB_OVF = 5;
  localparam int FSS_SB_OCF = 4;
  localparam int FSS_SB_TEMP = 2;
  localparam int FSS_SB_COMM = 1;
  localparam int FSS_SB_OTHER = 0;

  // Summary word high byte bit positions
  localparam int FSS_SW_VOLT = 7;
  localparam int FSS_SW_CURR = 6;
  localparam int FSS_SW_INPUT = 5;
  localparam int FSS_SW_VENDOR = 4;
  localparam int FSS_SW_PNG = 3;

  // Detailed register bit positions
  localparam int FSS_V_OVF = 7;
  localparam int FSS_V_OVW = 6;
  localparam int FSS_V_UVW = 5;
  localparam int FSS_V_UVF = 4;
  localparam int FSS_V_LIM = 3;
  localparam int FSS_V_RISE = 2;
  localparam int FSS_I_OCF = 7;
  localparam int FSS_I_OCW = 5;
  localparam int FSS_IN_LOW = 3;
  localparam int FSS_T_OTF = 7;
  localparam int FSS_T_OTW = 6;
  localparam int FSS_M_BG = 7;
  localparam int FSS_M_RAIL = 6;

  // Reset values
  localparam logic FSS_LOWSUP_RST = 1'b1;
  localparam logic FSS_PNG_MASK_RST = 1'b1;
  localparam logic FSS_FLAG_RST = 1'b0;

  // Latched source flags, also used for event inputs and alert masks
  typedef struct packed {
    logic vout_overvoltage_fault;
    logic overvoltage_warning;
    logic undervoltage_warning;
    logic undervoltage_fault;
    logic setpoint_limit_warning;
    logic rise_timeout_fault;
    logic overcurrent_fault;
    logic overcurrent_warning;
    logic temp_fault;
    logic temp_warning;
    logic bandgap_overtemp_fault;
    logic internal_rail_fault;
  } fss_src_t;

  localparam int FSS_NSRC = 12;

endpackage

// *** rtl/fss_flag.sv ***
// One sticky status flag: set wins over clear
`timescale 1ns/1ps
module fss_flag
  import fss_pkg::*;
#(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clk_in, // Clock
  input wire logic rstn_in, // Async reset, active low
  input wire logic set_in, // Condition present
  input wire logic clr_in, // Host clear
  output logic flag_out // Latched flag
);
  logic flag_d;

  always_comb begin
    flag_d = flag_out;
    if (clr_in) begin
      flag_d = 1'b0;
    end
    if (set_in) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      flag_out <= RESET_VAL;
    end else begin
      flag_out <= flag_d;
    end
  end
endmodule

// *** rtl/fss_png_gate.sv ***
// Power-not-good alert gate: held off until power good first rises
`timescale 1ns/1ps
module fss_png_gate
  import fss_pkg::*;
(
  input wire logic clk_in, // Clock
  input wire logic rstn_in, // Async reset, active low
  input wire logic power_good_in, // Live power good
  input wire logic mask_in, // Alert mask for power-not-good
  output logic alert_req_out // Power-not-good may raise alert
);
  logic seen_q;
  logic seen_d;

  always_comb begin
    seen_d = seen_q | power_good_in;
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      seen_q <= 1'b0;
    end else begin
      seen_q <= seen_d;
    end
  end

  assign alert_req_out = seen_q & ~mask_in & ~power_good_in;
endmodule

// *** bench/fss_sva.sv ***
// Assertions on the fault status summary ports
`timescale 1ns/1ps
module fss_sva
  import fss_pkg::*;
(
  input wire logic clk_in, // Clock
  input wire logic rstn_in, // Async reset, active low
  input wire logic rd_req_in, // Read request
  input wire fss_src_t event_in, // Fault conditions
  input wire logic conv_enabled_in, // Converter enabled
  input wire logic power_good_in, // Live power good
  input wire logic loop_slave_in, // Loop slave
  input wire logic rd_valid_out, // Read valid
  input wire logic [7:0] sum_byte_out, // Summary byte
  input wire logic [15:0] sum_word_out // Summary word
);
  logic [1:0] age_q;
  logic [1:0] age_d;
  logic live;
  always_comb age_d = (age_q == 2'h3) ? age_q : age_q + 2'h1;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) age_q <= 2'h0;
    else age_q <= age_d;
  end
  assign live = age_q == 2'h3;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  sequence s_read;
    rd_req_in ##1 rd_valid_out;
  endsequence
  property p_ack;
    rd_req_in |-> s_read;
  endproperty
  a_ack: assert property (p_ack) else $error("read not answered");
  property p_cause;
    rd_valid_out |-> $past(rd_req_in);
  endproperty
  a_cause: assert property (p_cause) else $error("valid without read");
  property p_low;
    sum_word_out[7:0] == sum_byte_out;
  endproperty
  a_low: assert property (p_low) else $error("word low byte differs");
  property p_zero;
    !sum_byte_out[7] && !sum_byte_out[3] && sum_word_out[10:8] == 3'h0;
  endproperty
  a_zero: assert property (p_zero) else $error("undefined bit set");
  property p_off;
    live |-> sum_byte_out[6] == !$past(conv_enabled_in);
  endproperty
  a_off: assert property (p_off) else $error("off bit wrong");
  property p_png;
    live |-> sum_word_out[11] == !$past(power_good_in);
  endproperty
  a_png: assert property (p_png) else $error("power not good wrong");
  property p_slave;
    live && $past(loop_slave_in) |-> !sum_byte_out[5];
  endproperty
  a_slave: assert property (p_slave) else $error("slave ovf set");
  property p_ocf;
    live && $past(event_in.overcurrent_fault, 2) |-> sum_byte_out[4] && sum_word_out[14];
  endproperty
  a_ocf: assert property (p_ocf) else $error("ocf summary missing");
  property p_temp;
    live && $past(event_in.temp_warning, 2) |-> sum_byte_out[2];
  endproperty
  a_temp: assert property (p_temp) else $error("temp summary missing");
  property p_vend;
    live && $past(event_in.internal_rail_fault, 2) |-> sum_word_out[12] && sum_byte_out[0];
  endproperty
  a_vend: assert property (p_vend) else $error("vendor summary missing");
endmodule
bind fss_top fss_sva chk_u (.clk_in, .rstn_in, .rd_req_in, .event_in, .conv_enabled_in,
  .power_good_in, .loop_slave_in, .rd_valid_out, .sum_byte_out, .sum_word_out);

// *** bench/fss_host_model.sv ***
// Host model: one-cycle read and write requests on the status port
`timescale 1ns/1ps
module fss_host_model (
  input wire logic clk_in, // Clock
  output logic [7:0] cmd_out, // Command code
  output logic rd_out, // Read pulse
  output logic wr_out, // Write pulse
  output logic [15:0] data_out // Write data
);
  initial begin
    cmd_out = 8'h00;
    rd_out = 1'b0;
    wr_out = 1'b0;
    data_out = 16'h0000;
  end
  task automatic rd(input logic [7:0] c);
    @(negedge clk_in);
    cmd_out = c;
    rd_out = 1'b1;
    @(negedge clk_in);
    rd_out = 1'b0;
    cmd_out = ~c;
  endtask
  // Ones clear the addressed flags
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(negedge clk_in);
    cmd_out = c;
    data_out = d;
    wr_out = 1'b1;
    @(negedge clk_in);
    wr_out = 1'b0;
    cmd_out = ~c;
    data_out = ~d;
  endtask
endmodule

// *** bench/fss_top_bench.sv ***
// Bench for the fault status summary block
`timescale 1ns/1ps
module fss_top_bench;
  import fss_pkg::*;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  fss_src_t ev, msk;
  logic vlow, en, pg, slave, pmw, pmd, vlmsk;
  logic [7:0] comm, cmd;
  logic rdq, wrq, rvalid, alert;
  logic [15:0] wdat, rdata;
  int fail_count, total_checks, cyc;
  logic [15:0] expq[$];
  logic [7:0] cmd_t[12] = '{8'h80, 8'h80, 8'h7D, 8'h7D, 8'h7B, 8'h7B, 8'h7A, 8'h7A, 8'h7A,
    8'h7A, 8'h7A, 8'h7A};
  int bit_t[12] = '{6, 7, 6, 7, 5, 7, 2, 3, 4, 5, 6, 7};
  logic [15:0] word_t[12] = '{16'h1001, 16'h1001, 16'h0004, 16'h0004, 16'h4001, 16'h4010,
    16'h8001, 16'h8001, 16'h8001, 16'h8001, 16'h8001, 16'h8020};
  fss_host_model host_u (.clk_in(clk_in), .cmd_out(cmd), .rd_out(rdq), .wr_out(wrq),
    .data_out(wdat));
  fss_top dut_u (.clk_in(clk_in), .rstn_in(rstn_in), .cmd_in(cmd), .rd_req_in(rdq),
    .wr_req_in(wrq), .wr_data_in(wdat), .event_in(ev), .mask_in(msk), .vin_low_in(vlow),
    .vin_low_mask_in(vlmsk), .comm_status_in(comm), .conv_enabled_in(en),
    .power_good_in(pg), .loop_slave_in(slave), .png_mask_wr_in(pmw),
    .png_mask_data_in(pmd), .rd_data_out(rdata), .rd_valid_out(rvalid),
    .sum_byte_out(), .sum_word_out(), .alert_out(alert));
  always #2.5 clk_in = ~clk_in;
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 4000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("FAIL %s exp %h got %h", n, e, g);
    end
  endtask
  always @(negedge clk_in) if (rvalid === 1'b1) chk("rd_data", expq.pop_front(), rdata);
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    expq.push_back(e);
    host_u.rd(c);
  endtask
  task automatic pulse_ev(input int i);
    ev[i] = 1'b1;
    @(negedge clk_in);
    ev[i] = 1'b0;
    repeat (3) @(negedge clk_in);
  endtask
  initial begin
    ev = '0;
    msk = '1;
    {vlow, en, pg, slave, pmw, pmd} = 6'h20;
    vlmsk = 1'b0;
    comm = 8'h00;
    void'($urandom(32'hD2270502));
    repeat (5) @(negedge clk_in);
    rstn_in = 1'b1;
    rd(8'h79, 16'h2841);
    rd(8'h78, 16'h0041);
    rd(8'h55, 16'h0000);
    pmw = 1'b1;
    @(negedge clk_in);
    pmw = 1'b0;
    repeat (3) @(negedge clk_in);
    chk("alert", 16'h0000, {15'h0000, alert});
    pg = 1'b1;
    repeat (3) @(negedge clk_in);
    pg = 1'b0;
    repeat (3) @(negedge clk_in);
    chk("alert", 16'h0001, {15'h0000, alert});
    pmd = 1'b1;
    pmw = 1'b1;
    @(negedge clk_in);
    pmw = 1'b0;
    pg = 1'b1;
    vlow = 1'b0;
    en = 1'b1;
    repeat (3) @(negedge clk_in);
    chk("alert", 16'h0000, {15'h0000, alert});
    rd(8'h79, 16'h0000);
    for (int i = 0; i < 12; i++) begin
      pulse_ev(i);
      chk("alert", 16'h0000, {15'h0000, alert});
      rd(8'h79, word_t[i]);
      host_u.wr(8'h79, 16'hFFFF);
      host_u.wr(8'h78, 16'hFFFF);
      rd(8'h78, {8'h00, word_t[i][7:0]});
      rd(cmd_t[i], 16'h0001 << bit_t[i]);
      host_u.wr(cmd_t[i], 16'h0001 << bit_t[i]);
      rd(8'h79, 16'h0000);
    end
    msk.vout_overvoltage_fault = 1'b0;
    pulse_ev(11);
    chk("alert", 16'h0001, {15'h0000, alert});
    host_u.wr(8'h7A, 16'h0080);
    repeat (2) @(negedge clk_in);
    chk("alert", 16'h0000, {15'h0000, alert});
    slave = 1'b1;
    pulse_ev(11);
    rd(8'h79, 16'h0000);
    slave = 1'b0;
    host_u.wr(8'h7A, 16'h0080);
    comm = 8'($urandom_range(255, 1));
    repeat (2) @(negedge clk_in);
    rd(8'h7E, {8'h00, comm});
    rd(8'h79, 16'h0002);
    vlow = 1'b1;
    @(negedge clk_in);
    vlow = 1'b0;
    repeat (2) @(negedge clk_in);
    chk("alert", 16'h0001, {15'h0000, alert});
    rd(8'h7C, 16'h0008);
    rd(8'h79, 16'h2003);
    host_u.wr(8'h7C, 16'h0008);
    repeat (2) @(negedge clk_in);
    chk("alert", 16'h0000, {15'h0000, alert});
    rd(8'h7C, 16'h0000);
    repeat (4) @(negedge clk_in);
    tally_and_finish();
  end
endmodule
